// ==== rtl/cl_video_frame_sequencer.sv ====
// frame sequencer of a base-mode camera link video source
// assumes apb on pclk; pixel clock and cc1 arrive asynchronous
//
// Behaviour
// - frame start waits until fifo holds the fill threshold, default 12 kB.
// - software may lower the threshold for images under 12 kB.
// - a started frame streams to its last pixel without refill pauses.
// - on empty fifo words are still sent, so that frame is corrupt.
// - no realignment after underflow; later frames may be skewed.
// - pixel clock, line and frame valid timing ignore fifo state.
// - after last line, blank for total count minus active lines.
// - after blanking, wait for fresh fifo data before next frame.
// - host stops output by stopping dma; threshold is never met.
// - active line count is copied to a held copy at frame start.
// - a host event can be raised on each frame-valid rise.
// - fill values, total count and read window are held per frame.
// - counter source makes data internally, no dma, frame start skips the fill threshold.
// - serial receive and transmit activity raise host events.
// - with loopback on, a received character is sent back unless the transmitter is busy or software writes the serial register in the same cycle.
// - optional frame start on cc1 rise, ignored unless start is ready.
// - optional line start on selected cc1 edge.
`timescale 1ns/100ps
module cl_video_frame_sequencer #(
	parameter int FIFO_DEPTH = 16384,
	localparam int LW = $clog2(FIFO_DEPTH) + 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pix_clk_in,
	input wire logic cc1_in,
	input wire logic dma_valid,
	input wire logic [7:0] dma_data,
	output logic dma_ready,
	output video_seq_pkg::video_s video,
	input wire video_seq_pkg::serial_byte_s uart_rx,
	output video_seq_pkg::serial_byte_s uart_tx,
	input wire logic uart_tx_ready,
	output logic frame_event,
	output logic uart_rx_event,
	output logic uart_tx_event
);
	typedef struct packed {
		video_seq_pkg::timing_s live;
		video_seq_pkg::timing_s hold;
		logic [7:0] c1_fill_a;
		logic [7:0] c1_fill_b;
		logic [15:0] c1_vact;
		logic [23:0] c1_vtot;
		logic [15:0] c1_hstart;
		logic [7:0] ctrl;
		logic [15:0] thresh;
		video_seq_pkg::seq_state_e st;
		logic [15:0] pix_cnt;
		logic [23:0] line_cnt;
		logic line_wait;
		logic line_pend;
		logic start_pend;
		logic [2:0] pix_sync;
		logic pix_lvl;
		logic [2:0] cc1_sync;
		logic cc1_lvl;
		video_seq_pkg::video_s vid;
		logic [7:0] pattern;
		logic underflow;
		logic [31:0] prdata;
		logic [7:0] rx_byte;
		logic rx_full;
		video_seq_pkg::serial_byte_s tx;
		logic frame_ev;
		logic rx_ev;
		logic tx_ev;
	} seq_state_s;

	seq_state_s s;
	seq_state_s n;
	logic pix_edge;
	logic cc1_rise;
	logic cc1_fall;
	logic fifo_empty;
	logic fifo_wr_ready;
	logic fifo_pop;
	logic [7:0] fifo_q;
	logic [LW-1:0] fifo_level;
	logic [9:0] idx;
	logic setup;
	logic access;

	// true when the word address names a register
	function automatic logic reg_hit(input logic [11:0] addr);
		logic [9:0] i;
		i = addr[11:2];
		reg_hit = 1'b0;
		if (addr[1:0] == 2'h0) begin
			case (i)
				video_seq_pkg::IDX_FILL_A, video_seq_pkg::IDX_FILL_B,
				video_seq_pkg::IDX_VACT, video_seq_pkg::IDX_VTOT,
				video_seq_pkg::IDX_HSTART, video_seq_pkg::IDX_HEND,
				video_seq_pkg::IDX_CH1_FILL_A, video_seq_pkg::IDX_CH1_FILL_B,
				video_seq_pkg::IDX_CH1_VACT, video_seq_pkg::IDX_CH1_VTOT,
				video_seq_pkg::IDX_CH1_HSTART, video_seq_pkg::IDX_CTRL,
				video_seq_pkg::IDX_STATUS, video_seq_pkg::IDX_THRESH,
				video_seq_pkg::IDX_UART: reg_hit = 1'b1;
				default: reg_hit = 1'b0;
			endcase
		end
	endfunction : reg_hit

	// last pixel clock of a line, blanking gap included
	function automatic logic line_end(input logic [15:0] cnt,
			input logic [15:0] hend);
		line_end = cnt == 16'(hend + video_seq_pkg::H_GAP - 16'h0001);
	endfunction : line_end

	// edges count only once second and third stage agree
	assign pix_edge = (s.pix_sync[1] == s.pix_sync[2]) & s.pix_sync[2] &
		~s.pix_lvl;
	assign cc1_rise = (s.cc1_sync[1] == s.cc1_sync[2]) & s.cc1_sync[2] &
		~s.cc1_lvl;
	assign cc1_fall = (s.cc1_sync[1] == s.cc1_sync[2]) & ~s.cc1_sync[2] &
		s.cc1_lvl;

	// zero-wait apb slave; bad addresses answer with an error
	assign idx = paddr[11:2];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign pslverr = access & ~reg_hit(paddr);
	assign prdata = s.prdata;

	// counter source keeps the host stream stalled
	assign dma_ready = fifo_wr_ready &
		~s.ctrl[video_seq_pkg::CTRL_SRC_COUNTER];

	assign video = s.vid;
	assign uart_tx = s.tx;
	assign frame_event = s.frame_ev;
	assign uart_rx_event = s.rx_ev;
	assign uart_tx_event = s.tx_ev;

	pixel_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.wr_valid(dma_valid & dma_ready),
		.wr_data(dma_data),
		.wr_ready(fifo_wr_ready),
		.rd_pop(fifo_pop),
		.rd_data(fifo_q),
		.empty(fifo_empty),
		.level(fifo_level)
	);

	// whole next-state computation of the block
	always_comb begin
		logic data_ok;
		logic in_window;
		logic [23:0] blank_lines;
		logic line_trig;
		data_ok = 1'b0;
		in_window = 1'b0;
		blank_lines = '0;
		line_trig = 1'b0;
		n = s;
		fifo_pop = 1'b0;
		n.frame_ev = 1'b0;
		n.rx_ev = 1'b0;
		n.tx_ev = 1'b0;

		// input synchronisers and settled levels
		n.pix_sync = {s.pix_sync[1:0], pix_clk_in};
		n.cc1_sync = {s.cc1_sync[1:0], cc1_in};
		if (s.pix_sync[1] == s.pix_sync[2]) begin
			n.pix_lvl = s.pix_sync[2];
		end
		if (s.cc1_sync[1] == s.cc1_sync[2]) begin
			n.cc1_lvl = s.cc1_sync[2];
		end

		// start is allowed once the fifo holds the threshold
		data_ok = s.ctrl[video_seq_pkg::CTRL_SRC_COUNTER] |
			(16'(fifo_level) >= s.thresh);
		if (s.st == video_seq_pkg::ST_READY && data_ok && !s.start_pend) begin
			if (!s.ctrl[video_seq_pkg::CTRL_FRAME_TRIG] || cc1_rise) begin
				n.start_pend = 1'b1;
			end
		end

		// line trigger on the chosen cc1 edge, only while a line waits
		line_trig = s.ctrl[video_seq_pkg::CTRL_LINE_FALL] ? cc1_fall :
			cc1_rise;
		if (s.line_wait && line_trig) begin
			n.line_pend = 1'b1;
		end

		blank_lines = s.hold.vtot - {8'h00, s.hold.vact};
		in_window = (s.pix_cnt >= s.hold.hstart) &&
			(s.pix_cnt < s.hold.hend);

		// sequencer runs on pixel clock edges only, fifo plays no part
		if (pix_edge) begin
			case (s.st)
				video_seq_pkg::ST_READY: begin
					n.vid.fval = 1'b0;
					n.vid.lval = 1'b0;
					n.vid.data = s.hold.fill_b;
					if (s.start_pend) begin
						// every held copy loads with frame valid
						n.hold = s.live;
						n.st = video_seq_pkg::ST_ACTIVE;
						n.start_pend = 1'b0;
						n.pix_cnt = '0;
						n.line_cnt = '0;
						n.line_wait = 1'b0;
						n.line_pend = 1'b0;
						n.vid.fval = 1'b1;
						n.vid.data = s.live.fill_a;
						n.frame_ev = s.ctrl[video_seq_pkg::CTRL_FRAME_EV];
					end
				end
				video_seq_pkg::ST_ACTIVE: begin
					n.vid.fval = 1'b1;
					n.vid.lval = 1'b0;
					n.vid.data = s.hold.fill_a;
					if (s.line_wait) begin
						if (s.line_pend) begin
							n.line_wait = 1'b0;
							n.line_pend = 1'b0;
							n.pix_cnt = '0;
						end
					end else begin
						if (in_window) begin
							// no stall on empty: stale word goes out
							n.vid.lval = 1'b1;
							if (s.ctrl[video_seq_pkg::CTRL_SRC_COUNTER]) begin
								n.vid.data = s.pattern;
								n.pattern = s.pattern + 8'h01;
							end else begin
								n.vid.data = fifo_q;
								fifo_pop = ~fifo_empty;
								if (fifo_empty) begin
									n.underflow = 1'b1;
								end
							end
						end
						n.pix_cnt = s.pix_cnt + 16'h0001;
						if (line_end(s.pix_cnt, s.hold.hend)) begin
							n.pix_cnt = '0;
							n.line_cnt = s.line_cnt + 24'h000001;
							n.line_wait = s.ctrl[video_seq_pkg::CTRL_LINE_TRIG];
							if (24'(s.line_cnt + 24'h000001) ==
									{8'h00, s.hold.vact}) begin
								n.line_cnt = '0;
								n.line_wait = 1'b0;
								n.vid.fval = 1'b0;
								n.vid.data = s.hold.fill_b;
								if (s.hold.vtot > {8'h00, s.hold.vact}) begin
									n.st = video_seq_pkg::ST_BLANK;
								end else begin
									n.st = video_seq_pkg::ST_READY;
								end
							end
						end
					end
				end
				video_seq_pkg::ST_BLANK: begin
					n.vid.fval = 1'b0;
					n.vid.lval = 1'b0;
					n.vid.data = s.hold.fill_b;
					n.pix_cnt = s.pix_cnt + 16'h0001;
					if (line_end(s.pix_cnt, s.hold.hend)) begin
						n.pix_cnt = '0;
						n.line_cnt = s.line_cnt + 24'h000001;
						if (24'(s.line_cnt + 24'h000001) == blank_lines) begin
							n.line_cnt = '0;
							n.st = video_seq_pkg::ST_READY;
						end
					end
				end
				default: begin
					n.st = video_seq_pkg::ST_READY;
				end
			endcase
		end

		// serial receive, optionally echoed straight back
		if (uart_rx.valid) begin
			n.rx_byte = uart_rx.data;
			n.rx_ev = s.ctrl[video_seq_pkg::CTRL_RX_EV];
			if (s.ctrl[video_seq_pkg::CTRL_LOOPBACK]) begin
				if (!s.tx.valid) begin
					n.tx.valid = 1'b1;
					n.tx.data = uart_rx.data;
				end
			end
		end
		if (s.tx.valid && uart_tx_ready) begin
			n.tx.valid = 1'b0;
			n.tx_ev = s.ctrl[video_seq_pkg::CTRL_TX_EV];
		end

		// read data captured in the setup phase
		if (setup) begin
			n.prdata = '0;
			case (reg_hit(paddr) ? idx : '0) // refused addresses read zero
				video_seq_pkg::IDX_FILL_A: n.prdata[7:0] = s.live.fill_a;
				video_seq_pkg::IDX_FILL_B: n.prdata[7:0] = s.live.fill_b;
				video_seq_pkg::IDX_VACT: n.prdata[15:0] = s.live.vact;
				video_seq_pkg::IDX_VTOT: n.prdata[23:0] = s.live.vtot;
				video_seq_pkg::IDX_HSTART: n.prdata[15:0] = s.live.hstart;
				video_seq_pkg::IDX_HEND: n.prdata[15:0] = s.live.hend;
				video_seq_pkg::IDX_CH1_FILL_A: n.prdata[7:0] = s.c1_fill_a;
				video_seq_pkg::IDX_CH1_FILL_B: n.prdata[7:0] = s.c1_fill_b;
				video_seq_pkg::IDX_CH1_VACT: n.prdata[15:0] = s.c1_vact;
				video_seq_pkg::IDX_CH1_VTOT: n.prdata[23:0] = s.c1_vtot;
				video_seq_pkg::IDX_CH1_HSTART: n.prdata[15:0] = s.c1_hstart;
				video_seq_pkg::IDX_CTRL: n.prdata[7:0] = s.ctrl;
				video_seq_pkg::IDX_THRESH: n.prdata[15:0] = s.thresh;
				video_seq_pkg::IDX_UART: n.prdata[7:0] = s.rx_byte;
				video_seq_pkg::IDX_STATUS: begin
					n.prdata[video_seq_pkg::STAT_UNDERFLOW] = s.underflow;
					n.prdata[video_seq_pkg::STAT_FVAL] = s.vid.fval;
					n.prdata[video_seq_pkg::STAT_BLANK] =
						s.st == video_seq_pkg::ST_BLANK;
					n.prdata[video_seq_pkg::STAT_READY] =
						s.st == video_seq_pkg::ST_READY;
					n.prdata[video_seq_pkg::STAT_RX_FULL] = s.rx_full;
					n.prdata[video_seq_pkg::STAT_TX_BUSY] = s.tx.valid;
					n.prdata[video_seq_pkg::STAT_LEVEL_LSB +: 16] =
						16'(fifo_level);
				end
				default: n.prdata = '0;
			endcase
		end

		// reading the serial register empties it
		if (access && !pwrite && idx == video_seq_pkg::IDX_UART &&
				reg_hit(paddr)) begin
			n.rx_full = 1'b0;
		end

		// writes take effect in the access phase
		if (access && pwrite && reg_hit(paddr)) begin
			case (idx)
				video_seq_pkg::IDX_FILL_A: n.live.fill_a = pwdata[7:0];
				video_seq_pkg::IDX_FILL_B: n.live.fill_b = pwdata[7:0];
				video_seq_pkg::IDX_VACT: n.live.vact = pwdata[15:0];
				video_seq_pkg::IDX_VTOT: n.live.vtot = pwdata[23:0];
				video_seq_pkg::IDX_HSTART: n.live.hstart = pwdata[15:0];
				video_seq_pkg::IDX_HEND: n.live.hend = pwdata[15:0];
				video_seq_pkg::IDX_CH1_FILL_A: n.c1_fill_a = pwdata[7:0];
				video_seq_pkg::IDX_CH1_FILL_B: n.c1_fill_b = pwdata[7:0];
				video_seq_pkg::IDX_CH1_VACT: n.c1_vact = pwdata[15:0];
				video_seq_pkg::IDX_CH1_VTOT: n.c1_vtot = pwdata[23:0];
				video_seq_pkg::IDX_CH1_HSTART: n.c1_hstart = pwdata[15:0];
				video_seq_pkg::IDX_CTRL: n.ctrl = pwdata[7:0];
				video_seq_pkg::IDX_THRESH: n.thresh = pwdata[15:0];
				video_seq_pkg::IDX_UART: begin
					// a write while busy is dropped, no queue here
					if (!s.tx.valid) begin
						n.tx.valid = 1'b1;
						n.tx.data = pwdata[7:0];
					end
				end
				video_seq_pkg::IDX_STATUS: begin
					if (pwdata[video_seq_pkg::STAT_UNDERFLOW]) begin
						n.underflow = 1'b0;
					end
				end
				default: n.ctrl = s.ctrl;
			endcase
		end

		// hardware sets win over software clears
		if (uart_rx.valid) begin
			n.rx_full = 1'b1;
		end
		if (pix_edge && s.st == video_seq_pkg::ST_ACTIVE && !s.line_wait &&
				in_window && fifo_empty &&
				!s.ctrl[video_seq_pkg::CTRL_SRC_COUNTER]) begin
			n.underflow = 1'b1;
		end
	end

	// single state register of the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.live.fill_a <= video_seq_pkg::FILL_RST;
			s.live.fill_b <= video_seq_pkg::FILL_RST;
			s.live.vact <= video_seq_pkg::VACT_RST;
			s.live.vtot <= video_seq_pkg::VTOT_RST;
			s.live.hstart <= video_seq_pkg::HSTART_RST;
			s.live.hend <= video_seq_pkg::HEND_RST;
			s.hold.vact <= video_seq_pkg::VACT_RST;
			s.hold.vtot <= video_seq_pkg::VTOT_RST;
			s.hold.hend <= video_seq_pkg::HEND_RST;
			s.ctrl <= video_seq_pkg::CTRL_RST;
			s.thresh <= video_seq_pkg::THRESH_RST;
			s.st <= video_seq_pkg::ST_READY;
		end else begin
			s <= n;
		end
	end

endmodule : cl_video_frame_sequencer

// ==== rtl/video_seq_pkg.sv ====
// constants, types and register map of the video frame sequencer
// assumes an apb slave at byte address = register index * 4
package video_seq_pkg;

	// register indices; the byte address is four times the index
	localparam logic [9:0] IDX_FILL_A = 10'h044;
	localparam logic [9:0] IDX_FILL_B = 10'h046;
	localparam logic [9:0] IDX_VACT = 10'h04A;
	localparam logic [9:0] IDX_VTOT = 10'h04C;
	localparam logic [9:0] IDX_HSTART = 10'h058;
	localparam logic [9:0] IDX_HEND = 10'h05A;
	localparam logic [9:0] IDX_CH1_FILL_A = 10'h0C4;
	localparam logic [9:0] IDX_CH1_FILL_B = 10'h0C6;
	localparam logic [9:0] IDX_CH1_VACT = 10'h0CA;
	localparam logic [9:0] IDX_CH1_VTOT = 10'h0CC;
	localparam logic [9:0] IDX_CH1_HSTART = 10'h0D8;
	localparam logic [9:0] IDX_CTRL = 10'h060;
	localparam logic [9:0] IDX_STATUS = 10'h061;
	localparam logic [9:0] IDX_THRESH = 10'h062;
	localparam logic [9:0] IDX_UART = 10'h063;

	// reset values
	localparam logic [7:0] FILL_RST = 8'h00;
	localparam logic [15:0] VACT_RST = 16'h0010;
	localparam logic [23:0] VTOT_RST = 24'h000014;
	localparam logic [15:0] HSTART_RST = 16'h0000;
	localparam logic [15:0] HEND_RST = 16'h0010;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] THRESH_RST = 16'h3000; // 12 kB of host data

	// pixel clocks of horizontal blanking after the read-valid end
	localparam logic [15:0] H_GAP = 16'h0004;

	// control bits
	localparam int CTRL_SRC_COUNTER = 0;
	localparam int CTRL_FRAME_TRIG = 1;
	localparam int CTRL_LINE_TRIG = 2;
	localparam int CTRL_LINE_FALL = 3;
	localparam int CTRL_LOOPBACK = 4;
	localparam int CTRL_FRAME_EV = 5;
	localparam int CTRL_RX_EV = 6;
	localparam int CTRL_TX_EV = 7;

	// status bits
	localparam int STAT_UNDERFLOW = 0;
	localparam int STAT_FVAL = 1;
	localparam int STAT_BLANK = 2;
	localparam int STAT_READY = 3;
	localparam int STAT_RX_FULL = 4;
	localparam int STAT_TX_BUSY = 5;
	localparam int STAT_LEVEL_LSB = 16;

	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_BLANK = 2'b11
	} seq_state_e;

	// per-frame timing, live copy and held copy
	typedef struct packed {
		logic [7:0] fill_a;
		logic [7:0] fill_b;
		logic [15:0] vact;
		logic [23:0] vtot;
		logic [15:0] hstart;
		logic [15:0] hend;
	} timing_s;

	// video link outputs
	typedef struct packed {
		logic fval;
		logic lval;
		logic [7:0] data;
	} video_s;

	// one serial character with its strobe
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} serial_byte_s;

endpackage : video_seq_pkg

// ==== rtl/pixel_fifo.sv ====
// byte fifo for host image data, read data from a register
// assumes one clock for both sides; memory itself has no reset
`timescale 1ns/100ps
module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16384,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic [WIDTH-1:0] wr_data,
	output logic wr_ready,
	input wire logic rd_pop,
	output logic [WIDTH-1:0] rd_data,
	output logic empty,
	output logic [AW:0] level
);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic [WIDTH-1:0] q;
	} fifo_state_s;

	fifo_state_s s;
	fifo_state_s n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// pointers carry one extra bit so full and empty differ
	assign level = s.wp - s.rp;
	assign wr_ready = level != (AW + 1)'(DEPTH);
	assign empty = level == '0;
	assign push = wr_valid & wr_ready;
	assign pop = rd_pop & ~empty;
	assign rd_data = s.q;

	// head word lags a pointer move by one clock
	always_comb begin
		n = s;
		if (push) begin
			n.wp = s.wp + (AW + 1)'(1);
		end
		if (pop) begin
			n.rp = s.rp + (AW + 1)'(1);
		end
		n.q = mem[s.rp[AW-1:0]];
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[s.wp[AW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule : pixel_fifo

// ==== tb/seq_checker.sv ====
// port assertions for the frame sequencer
// assumes binding into the sequencer; ctrl is shadowed from apb writes
`timescale 1ns/100ps
module seq_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic dma_ready,
	input wire video_seq_pkg::video_s video,
	input wire video_seq_pkg::serial_byte_s uart_rx,
	input wire video_seq_pkg::serial_byte_s uart_tx,
	input wire logic uart_tx_ready,
	input wire logic frame_event,
	input wire logic uart_rx_event
);
	logic [7:0] ctl;
	logic [7:0] rx_last;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// shadow copies, since enables are not visible at the ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= 8'h00;
			rx_last <= 8'h00;
		end else begin
			if (psel && penable && pwrite
				&& paddr == {video_seq_pkg::IDX_CTRL, 2'b00})
				ctl <= pwdata[7:0];
			if (uart_rx.valid)
				rx_last <= uart_rx.data;
		end
	end

	property p_fev_fval;
		frame_event |-> video.fval;
	endproperty
	a_fev_fval: assert property (p_fev_fval)
		else $error("frame event outside frame");
	property p_fev_rise;
		$rose(video.fval) && ctl[5] |-> ##[0:1] frame_event;
	endproperty
	a_fev_rise: assert property (p_fev_rise)
		else $error("frame event missing");
	property p_fev_pulse;
		frame_event |=> !frame_event;
	endproperty
	a_fev_pulse: assert property (p_fev_pulse)
		else $error("frame event too long");
	// link fields move only on pixel edges, eight pclk apart
	property p_vid_hold;
		!$stable(video) |=> $stable(video) [*5];
	endproperty
	a_vid_hold: assert property (p_vid_hold)
		else $error("video changed between pixel edges");
	property p_lval_fval;
		video.lval |-> video.fval;
	endproperty
	a_lval_fval: assert property (p_lval_fval)
		else $error("line valid outside frame");
	property p_src_cnt;
		ctl[0] |-> !dma_ready;
	endproperty
	a_src_cnt: assert property (p_src_cnt)
		else $error("dma accepted with counter source");
	property p_rx_ev;
		uart_rx.valid && ctl[6] |=> uart_rx_event;
	endproperty
	a_rx_ev: assert property (p_rx_ev)
		else $error("receive event missing");
	property p_loop;
		uart_rx.valid && ctl[4] && !uart_tx.valid
			|-> ##[1:4] (uart_tx.valid && uart_tx.data == rx_last);
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopback character missing");
	property p_tx_hold;
		uart_tx.valid && !uart_tx_ready
			|=> uart_tx.valid && $stable(uart_tx.data);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("serial output dropped before handshake");
	property p_apb_err;
		psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
	endproperty
	a_apb_err: assert property (p_apb_err)
		else $error("misaligned access not refused");
endmodule : seq_checker

// ==== tb/grabber_model.sv ====
// frame grabber model: pixel clock, cc1 and serial handshake
// assumes the sequencer's pclk for the serial side
`timescale 1ns/100ps
module grabber_model (
	input wire logic pclk,
	input wire video_seq_pkg::video_s video,
	input wire video_seq_pkg::serial_byte_s uart_tx,
	output logic uart_tx_ready,
	output logic pix_clk_in,
	output logic cc1_in
);
	logic [7:0] got[$];
	logic [7:0] fill_seen;
	logic [7:0] idle_seen;
	logic [7:0] echo;
	logic prev_f = 1'b0;
	logic prev_l = 1'b0;
	int lines = 0;
	int gap = 0;
	int blank = 0;
	int tx_wait = 0;
	int slow = 3;

	// free running: frames cannot start without pixel edges
	initial pix_clk_in = 1'b0;
	always #400 pix_clk_in = !pix_clk_in;
	initial cc1_in = 1'b0;

	// sample about half a pixel period after a change, when settled
	always @(posedge pix_clk_in) begin
		if (!video.fval)
			gap++;
		if (!video.fval)
			idle_seen = video.data;
		if (video.fval && !prev_f) begin
			blank = gap;
			gap = 0;
			lines = 0;
		end
		if (video.lval && !prev_l)
			lines++;
		if (video.lval)
			got.push_back(video.data);
		else if (video.fval)
			fill_seen = video.data;
		prev_f = video.fval;
		prev_l = video.lval;
	end

	// slow acceptance on purpose, so the sender must hold its byte
	assign uart_tx_ready = uart_tx.valid && tx_wait >= slow;
	always @(posedge pclk) begin
		tx_wait <= (uart_tx.valid && !uart_tx_ready) ? tx_wait + 1 : 0;
		if (uart_tx.valid && uart_tx_ready)
			echo <= uart_tx.data;
	end

	// trigger pulse on camera control line
	task automatic pulse_cc1();
		cc1_in = 1'b1;
		#1600 cc1_in = 1'b0;
	endtask : pulse_cc1
endmodule : grabber_model

// ==== tb/cl_video_frame_sequencer_bench.sv ====
// self-checking bench of the frame sequencer with a grabber model
// assumes apb byte address = register index * 4
`timescale 1ns/100ps
module cl_video_frame_sequencer_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pix_clk_in;
	logic cc1_in;
	logic dma_valid = 1'b0;
	logic [7:0] dma_data = 8'h00;
	logic dma_ready;
	video_seq_pkg::video_s video;
	video_seq_pkg::serial_byte_s uart_rx = 9'h000;
	video_seq_pkg::serial_byte_s uart_tx;
	logic uart_tx_ready;
	logic frame_event;
	logic uart_rx_event;
	logic uart_tx_event;
	logic [31:0] rd;
	logic err;
	logic [7:0] sent[$];
	int bad_count = 0;
	int comparisons = 0;
	int i;
	int tx_events = 0;

	always #50 pclk = !pclk;

	// transmit events counted here, the pulse lasts one clock only
	always @(posedge pclk)
		if (uart_tx_event === 1'b1)
			tx_events++;

	cl_video_frame_sequencer cl_video_frame_sequencer_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pix_clk_in, .cc1_in, .dma_valid, .dma_data, .dma_ready,
		.video, .uart_rx, .uart_tx, .uart_tx_ready, .frame_event,
		.uart_rx_event, .uart_tx_event);
	grabber_model grabber_model_i (.pclk, .video, .uart_tx,
		.uart_tx_ready, .pix_clk_in, .cc1_in);

	// one apb transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no limit of its own: only the watchdog ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	// host bytes, numbered so order and loss show up
	task automatic push(input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge pclk);
			dma_valid <= 1'b1;
			dma_data <= 8'hA0 + 8'(sent.size());
			sent.push_back(8'hA0 + 8'(sent.size()));
			@(negedge pclk);
			while (dma_ready !== 1'b1)
				@(negedge pclk);
			@(posedge pclk);
			dma_valid <= 1'b0;
		end
	endtask : push

	// sampled on the falling edge, away from register updates
	task automatic wait_fv(input logic v, input int lim);
		int n;
		for (n = 0; n < lim && video.fval !== v; n++)
			@(negedge pclk);
		repeat (10) @(negedge pclk);
	endtask : wait_fv

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, video_seq_pkg::IDX_THRESH, 0);
		chk("threshold", 32'h3000, rd);
		apb(0, video_seq_pkg::IDX_VACT, 0);
		chk("active lines", 32'h10, rd);
		apb(0, 10'h001, 0);
		chk("unmapped", 1, err);
		// small frame: 2 lines of 4 pixels, line length 8
		apb(1, video_seq_pkg::IDX_THRESH, 8);
		apb(1, video_seq_pkg::IDX_VACT, 2);
		apb(1, video_seq_pkg::IDX_VTOT, 4);
		apb(1, video_seq_pkg::IDX_HEND, 4);
		apb(1, video_seq_pkg::IDX_FILL_A, 32'h5A);
		apb(1, video_seq_pkg::IDX_FILL_B, 32'hB5);
		apb(1, video_seq_pkg::IDX_CTRL, 32'hF0);
		push(7);
		wait_fv(1, 80);
		chk("early frame", 0, video.fval);
		push(1);
		wait_fv(1, 100);
		chk("frame start", 1, video.fval);
		// next frame's settings written while this one runs
		apb(1, video_seq_pkg::IDX_VACT, 3);
		apb(1, video_seq_pkg::IDX_FILL_A, 32'h66);
		wait_fv(0, 400);
		chk("lines", 2, grabber_model_i.lines);
		chk("fill a", 32'h5A, grabber_model_i.fill_seen);
		for (i = 0; i < 8; i++)
			chk("pixel", sent[i], grabber_model_i.got[i]);
		wait_fv(1, 600);
		chk("no data frame", 0, video.fval);
		chk("fill b", 32'hB5, grabber_model_i.idle_seen);
		// 12 pixels with only 8 bytes: underflow mid-frame
		push(8);
		wait_fv(1, 100);
		wait_fv(0, 800);
		chk("lines", 3, grabber_model_i.lines);
		chk("words", 20, grabber_model_i.got.size());
		apb(1, video_seq_pkg::IDX_CTRL, 32'hF1);
		wait_fv(1, 200);
		chk("counter frame", 1, video.fval);
		chk("dma ready", 0, dma_ready);
		chk("blank", 1, grabber_model_i.blank inside {[7:10]});
		apb(0, video_seq_pkg::IDX_STATUS, 0);
		chk("underflow", 1, rd[0]);
		apb(1, video_seq_pkg::IDX_STATUS, 1);
		apb(0, video_seq_pkg::IDX_STATUS, 0);
		chk("cleared", 0, rd[0]);
		wait_fv(0, 800);
		apb(1, video_seq_pkg::IDX_CTRL, 32'hF3);
		wait_fv(1, 400);
		chk("no trigger", 0, video.fval);
		grabber_model_i.pulse_cc1();
		wait_fv(1, 100);
		chk("trigger", 1, video.fval);
		wait_fv(0, 800);
		apb(1, video_seq_pkg::IDX_CTRL, 32'hF0);
		wait_fv(1, 600);
		chk("stopped", 0, video.fval);
		// each line after the first waits for its cc1 edge
		apb(1, video_seq_pkg::IDX_CTRL, 32'hF5);
		wait_fv(1, 200);
		repeat (100) @(negedge pclk);
		chk("line wait", 1, grabber_model_i.lines);
		grabber_model_i.pulse_cc1();
		repeat (100) @(negedge pclk);
		chk("line trigger", 2, grabber_model_i.lines);
		apb(1, video_seq_pkg::IDX_CTRL, 32'hFD);
		grabber_model_i.pulse_cc1();
		wait_fv(0, 200);
		chk("fall trigger", 3, grabber_model_i.lines);
		@(posedge pclk);
		uart_rx <= {1'b1, 8'h3C};
		@(posedge pclk);
		uart_rx <= 9'h000;
		repeat (20) @(posedge pclk);
		chk("echo", 32'h3C, grabber_model_i.echo);
		chk("tx event", 1, tx_events);
		apb(0, video_seq_pkg::IDX_UART, 0);
		chk("rx byte", 32'h3C, rd);
		summarize();
	end

	// watchdog, far beyond the expected run
	initial begin
		#3000000;
		bad_count++;
		summarize();
	end
endmodule : cl_video_frame_sequencer_bench

bind cl_video_frame_sequencer seq_checker seq_checker_i (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
	.dma_ready, .video, .uart_rx, .uart_tx, .uart_tx_ready,
	.frame_event, .uart_rx_event);
